// ===== pawu_consts.vh
`ifndef PAWU_CONSTS_VH
`define PAWU_CONSTS_VH

// Register selects on the data-memory register port
`define PAWU_SEL_W 3
`define PAWU_SEL_DATA 3'h0
`define PAWU_SEL_DIR 3'h1
`define PAWU_SEL_PULLUP 3'h2
`define PAWU_SEL_WAKE 3'h3
`define PAWU_SEL_SYSCTL 3'h4
`define PAWU_SEL_ADCFG 3'h5
`define PAWU_SEL_TMRMODE 3'h6

// Reset values
`define PAWU_RST_DATA 8'hff
`define PAWU_RST_DIR 8'hff
`define PAWU_RST_PULLUP 8'h00
`define PAWU_RST_WAKE 8'h00
`define PAWU_RST_ZERO 8'h00

// Implemented bit masks; bits 3 and 4 are absent, bit 7 has no pull-up
`define PAWU_MASK_PORT 8'he7
`define PAWU_MASK_PULLUP 8'h67
`define PAWU_MASK_WAKE 8'he7

// Pin-shared function positions
`define PAWU_BIT_EXTINT 2
`define PAWU_BIT_TIMER 5
`define PAWU_BIT_BUZ 6
`define PAWU_BIT_BUZN 7
`define PAWU_SYS_BUZ 0
`define PAWU_SYS_BUZN 1

// Timer mode codes (two bits)
`define PAWU_TM_EVENT 2'h1
`define PAWU_TM_CAPTURE 2'h3

`endif

// ===== pawu_fall_det.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Asynchronous falling-edge catcher, one per port pin
// ----------------------------------------------------------------
module pawu_fall_det (
    pin,
    armed,
    clk,
    rstn,
    caught
);
    input wire pin;
    input wire armed;
    input wire clk;
    input wire rstn;
    output wire caught;

    reg hitQ;
    reg sync1Q;
    reg sync2Q;
    wire clrN;

    // Cleared while disarmed so a stale edge cannot wake later
    assign clrN = rstn & armed;

    // Pin itself is the clock: works with the system clock stopped
    always @(negedge pin or negedge clrN)
    begin
        if (!clrN)
            hitQ <= 1'b0;
        else
            hitQ <= 1'b1;
    end

    // Resynchronised once the core clock runs again
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1Q <= 1'b0;
            sync2Q <= 1'b0;
        end
        else
        begin
            sync1Q <= hitQ;
            sync2Q <= sync1Q;
        end
    end

    assign caught = sync2Q;
endmodule // pawu_fall_det

// ===== pawu_pin_model.sv
`timescale 1ns/1ps
module pawu_pin_model (
    input wire clk,
    input wire [7:0] padOut,
    input wire [7:0] padOe,
    input wire [7:0] pullupOn,
    input wire [7:0] swLevel,
    input wire [7:0] swOn,
    output wire [7:0] padIn
);
    // Open pins wander, so a stale level never reads as valid
    reg [7:0] floatQ = 8'h5a;
    always @(posedge clk)
        floatQ <= ~floatQ;
    // Driver first, then switch, then weak pull-up
    assign padIn = (padOe & padOut) | (~padOe & swOn & swLevel)
        | (~padOe & ~swOn & (pullupOn | floatQ));
endmodule // pawu_pin_model

// ===== pawu_port.v
`timescale 1ns/1ps
`include "pawu_consts.vh"
// Functional notes
// - Port reads of input pins return the pin level sampled at the read, nothing latched.
// - Written port data stays in the output latch until written again.
// - Direction bit one makes an input, zero a CMOS output; resets to ones.
// - Reading an output pin returns its latch, not the pin level.
// - Pull-up bits 0-2,5,6 enable a weak pull-up; register resets to zero.
// - Pull-up applies only to inputs, and pin seven has none.
// - Wake bits 0-2,5-7 enable wake per pin; register resets to zero.
// - Unimplemented bits of wake, direction and pull-up read as zero.
// - Halt puts the device to sleep with clock stopped until a wake event.
// - In sleep a falling edge on any wake-enabled pin wakes the core.
// - After reset data latch and direction are all ones.
// - Bit set and clear are read-modify-write of the whole port.
// - Timer pin feeds the timer only in event or capture mode as input.
// - Buzzer outputs reach pins only when direction selects output.
// - Pins selected as analog inputs lose their pull-up automatically.
module pawu_port #(
    parameter WIDTH = 8
) (
    clk,
    rstn,
    regSel,
    regWr,
    regWdata,
    regRd,
    bitOp,
    bitSet,
    bitIdx,
    halt,
    padIn,
    buzIn,
    buzNIn,
    regRdata,
    padOut,
    padOe,
    pullupOn,
    sleeping,
    clockStop,
    wakeEvt,
    extIntPin,
    timerPin,
    timerPinValid
);
    input wire clk;
    input wire rstn;
    input wire [`PAWU_SEL_W-1:0] regSel;
    input wire regWr;
    input wire [WIDTH-1:0] regWdata;
    input wire regRd;
    input wire bitOp;
    input wire bitSet;
    input wire [2:0] bitIdx;
    input wire halt;
    input wire [WIDTH-1:0] padIn;
    input wire buzIn;
    input wire buzNIn;
    output reg [WIDTH-1:0] regRdata;
    output reg [WIDTH-1:0] padOut;
    output reg [WIDTH-1:0] padOe;
    output reg [WIDTH-1:0] pullupOn;
    output reg sleeping;
    output reg clockStop;
    output reg wakeEvt;
    output reg extIntPin;
    output reg timerPin;
    output reg timerPinValid;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [WIDTH-1:0] dataQ;
    reg [WIDTH-1:0] dirQ;
    reg [WIDTH-1:0] pullQ;
    reg [WIDTH-1:0] wakeQ;
    reg [WIDTH-1:0] sysCtlQ;
    reg [WIDTH-1:0] adCfgQ;
    reg [WIDTH-1:0] tmrModeQ;
    reg [WIDTH-1:0] wrVal;
    reg [WIDTH-1:0] rdVal;
    wire [WIDTH-1:0] portView;
    wire [WIDTH-1:0] caught;
    wire anyWake;
    wire [1:0] tmMode;

    // Outputs show the latch, inputs the live pin
    assign portView = (dirQ & padIn) | (~dirQ & dataQ);

    // Bit ops read the whole port, change one bit, write all back
    always @*
    begin
        wrVal = regWdata;
        if (bitOp)
        begin
            case (regSel)
                `PAWU_SEL_DATA: wrVal = portView;
                `PAWU_SEL_DIR: wrVal = dirQ;
                `PAWU_SEL_PULLUP: wrVal = pullQ;
                `PAWU_SEL_WAKE: wrVal = wakeQ;
                `PAWU_SEL_SYSCTL: wrVal = sysCtlQ;
                `PAWU_SEL_ADCFG: wrVal = adCfgQ;
                `PAWU_SEL_TMRMODE: wrVal = tmrModeQ;
                default: wrVal = regWdata;
            endcase
            wrVal[bitIdx] = bitSet;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dataQ <= `PAWU_RST_DATA;
            dirQ <= `PAWU_RST_DIR;
            pullQ <= `PAWU_RST_PULLUP;
            wakeQ <= `PAWU_RST_WAKE;
            sysCtlQ <= `PAWU_RST_ZERO;
            adCfgQ <= `PAWU_RST_ZERO;
            tmrModeQ <= `PAWU_RST_ZERO;
        end
        else if (regWr | bitOp)
        begin
            case (regSel)
                `PAWU_SEL_DATA: dataQ <= wrVal & `PAWU_MASK_PORT;
                `PAWU_SEL_DIR: dirQ <= wrVal & `PAWU_MASK_PORT;
                `PAWU_SEL_PULLUP: pullQ <= wrVal & `PAWU_MASK_PULLUP;
                `PAWU_SEL_WAKE: wakeQ <= wrVal & `PAWU_MASK_WAKE;
                `PAWU_SEL_SYSCTL: sysCtlQ <= wrVal;
                `PAWU_SEL_ADCFG: adCfgQ <= wrVal;
                `PAWU_SEL_TMRMODE: tmrModeQ <= wrVal;
                default: dataQ <= dataQ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @*
    begin
        case (regSel)
            `PAWU_SEL_DATA: rdVal = portView & `PAWU_MASK_PORT;
            // Reset value sets the absent bits, so mask them on the way out
            `PAWU_SEL_DIR: rdVal = dirQ & `PAWU_MASK_PORT;
            `PAWU_SEL_PULLUP: rdVal = pullQ;
            `PAWU_SEL_WAKE: rdVal = wakeQ;
            `PAWU_SEL_SYSCTL: rdVal = sysCtlQ;
            `PAWU_SEL_ADCFG: rdVal = adCfgQ;
            `PAWU_SEL_TMRMODE: rdVal = tmrModeQ;
            default: rdVal = `PAWU_RST_ZERO;
        endcase
    end

    // Pin sampled on the read cycle edge, held until the next read
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            regRdata <= `PAWU_RST_ZERO;
        else if (regRd)
            regRdata <= rdVal;
    end

    // ----------------------------------------------------------------
    // Pad drive, pull-ups and pin-shared functions
    // ----------------------------------------------------------------
    assign tmMode = tmrModeQ[1:0];

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            padOut <= `PAWU_RST_DATA;
            padOe <= `PAWU_RST_ZERO;
            pullupOn <= `PAWU_RST_ZERO;
            extIntPin <= 1'b1;
            timerPin <= 1'b1;
            timerPinValid <= 1'b0;
        end
        else
        begin
            padOut <= dataQ;
            // Buzzer overrides the latch only while the pin is an output
            if (sysCtlQ[`PAWU_SYS_BUZ] && !dirQ[`PAWU_BIT_BUZ])
                padOut[`PAWU_BIT_BUZ] <= buzIn;
            if (sysCtlQ[`PAWU_SYS_BUZN] && !dirQ[`PAWU_BIT_BUZN])
                padOut[`PAWU_BIT_BUZN] <= buzNIn;
            padOe <= ~dirQ & `PAWU_MASK_PORT;
            // Analog selection drops the pull-up regardless of the bit
            pullupOn <= pullQ & dirQ & ~adCfgQ
                        & `PAWU_MASK_PULLUP;
            // Interrupt path stays live; enabling it is software's job
            extIntPin <= padIn[`PAWU_BIT_EXTINT];
            timerPin <= padIn[`PAWU_BIT_TIMER];
            timerPinValid <= dirQ[`PAWU_BIT_TIMER]
                             && (tmMode == `PAWU_TM_EVENT
                                 || tmMode == `PAWU_TM_CAPTURE);
        end
    end

    // ----------------------------------------------------------------
    // Sleep and wake
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1)
        begin : gWake
            pawu_fall_det uDet (
                .pin(padIn[gi]),
                .armed(wakeQ[gi] & sleeping),
                .clk(clk),
                .rstn(rstn),
                .caught(caught[gi])
            );
        end
    endgenerate

    assign anyWake = |(caught & wakeQ);

    // clockStop goes to the clock gate; the detector needs no clock
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sleeping <= 1'b0;
            clockStop <= 1'b0;
            wakeEvt <= 1'b0;
        end
        else
        begin
            wakeEvt <= 1'b0;
            if (!sleeping && halt)
            begin
                sleeping <= 1'b1;
                clockStop <= 1'b1;
            end
            else if (sleeping && anyWake)
            begin
                sleeping <= 1'b0;
                clockStop <= 1'b0;
                wakeEvt <= 1'b1;
            end
        end
    end
endmodule // pawu_port

// ===== pawu_port_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module pawu_port_props (
    input wire clk,
    input wire rstn,
    input wire [2:0] regSel,
    input wire regWr,
    input wire [7:0] regWdata,
    input wire regRd,
    input wire bitOp,
    input wire halt,
    input wire [7:0] padIn,
    input wire [7:0] regRdata,
    input wire [7:0] padOe,
    input wire [7:0] pullupOn,
    input wire sleeping,
    input wire clockStop,
    input wire wakeEvt
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire wr = regWr && !bitOp;
    wire quiet = !regWr && !bitOp;
    property p_dirOe;
        wr && regSel == 3'h1 |-> ##2 padOe == (~$past(regWdata, 2) & 8'he7);
    endproperty
    a_dirOe: assert property (p_dirOe) else $error("oe wrong");
    property p_dirRb;
        wr && regSel == 3'h1 ##1 regRd && quiet && regSel == 3'h1
            |=> regRdata == ($past(regWdata, 2) & 8'he7);
    endproperty
    a_dirRb: assert property (p_dirRb) else $error("dir read");
    property p_puRb;
        wr && regSel == 3'h2 ##1 regRd && quiet && regSel == 3'h2
            |=> regRdata == ($past(regWdata, 2) & 8'h67);
    endproperty
    a_puRb: assert property (p_puRb) else $error("pull read");
    property p_rdPort;
        regRd && quiet && regSel == 3'h0 && padOe == 8'h00 && !$past(regWr)
            && !$past(bitOp) |=> regRdata == ($past(padIn) & 8'he7);
    endproperty
    a_rdPort: assert property (p_rdPort) else $error("pin read");
    property p_pullOff;
        (pullupOn & (padOe | 8'h98)) == 8'h00;
    endproperty
    a_pullOff: assert property (p_pullOff) else $error("pull on");
    property p_sleep;
        halt && !sleeping |=> sleeping && clockStop;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
    property p_wakeEvt;
        wakeEvt == $fell(sleeping);
    endproperty
    a_wakeEvt: assert property (p_wakeEvt) else $error("wake");
    property p_noWake;
        $stable(padIn) [*6] ##0 sleeping |=> sleeping;
    endproperty
    a_noWake: assert property (p_noWake) else $error("woke");
endmodule // pawu_port_props

bind pawu_port pawu_port_props chk_u (.*);

// ===== port_a_io_wakeup_tb.sv
`timescale 1ns/1ps
module port_a_io_wakeup_tb;
    reg clk = 0, rstn = 0, regWr = 0, regRd = 0, bitOp = 0, bitSet = 0;
    reg halt = 0, buzIn = 0;
    reg [2:0] regSel = 0, bitIdx = 0;
    reg [7:0] regWdata = 0, swLevel = 8'hff, swOn = 8'hff, d, r, dir;
    wire [7:0] padIn, regRdata, padOut, padOe, pullupOn;
    wire sleeping, clockStop, wakeEvt, extIntPin, timerPin, timerPinValid;
    integer nErrors = 0, checks = 0, i;
    reg [31:0] seed = 32'h3977;
    pawu_port dut_u (.buzNIn(1'b0), .*);
    pawu_pin_model pin_u (.*);
    initial forever #12.5 clk = ~clk;
    function [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    function [7:0] view(input [7:0] dr, lt, pn);
        view = ((dr & pn) | (~dr & lt)) & 8'he7;
    endfunction
    task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp)
            begin
                nErrors = nErrors + 1;
                $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [2:0] s, input [7:0] v);
        begin
            regSel <= s;
            regWdata <= v;
            regWr <= 1'b1;
            @(posedge clk);
            regWr <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    task rd(input [2:0] s);
        begin
            regSel <= s;
            regRd <= 1'b1;
            @(posedge clk);
            regRd <= 1'b0;
            @(posedge clk);
            r = regRdata;
        end
    endtask
    task reportAndStop;
        begin
            $display("checks %0d errors %0d", checks, nErrors);
            if (nErrors == 0 && checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial
    begin
        #(25 * 20000);
        nErrors = nErrors + 1;
        reportAndStop;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(1);
        chk("dir", r, 8'he7);
        rd(2);
        chk("pull", r, 8'h00);
        rd(3);
        chk("wake", r, 8'h00);
        wr(1, 8'h00);
        chk("oe", padOe, 8'he7);
        rd(0);
        chk("latch", r, 8'he7);
        $display("reset test done");
        for (i = 0; i < 40; i = i + 1)
        begin
            seed = xs(seed);
            d = seed[7:0];
            dir = (i < 2) ? 8'hff : seed[23:16];
            swLevel <= seed[15:8];
            wr(0, d);
            wr(1, dir);
            rd(0);
            chk("view", r, view(dir, d, seed[15:8]));
        end
        $display("random test done");
        swLevel <= 8'hff;
        wr(1, 8'hf0);
        wr(0, 8'h00);
        bitSet <= 1'b1;
        bitOp <= 1'b1;
        @(posedge clk);
        bitOp <= 1'b0;
        @(posedge clk);
        wr(1, 8'h00);
        rd(0);
        chk("rmw", r, 8'he1);
        wr(1, 8'hff);
        wr(2, 8'hff);
        chk("puOn", pullupOn, 8'h67);
        wr(5, 8'h01);
        chk("adc", pullupOn, 8'h66);
        $display("pull test done");
        wr(4, 8'h01);
        buzIn <= 1'b1;
        wr(1, 8'hbf);
        chk("buz", {padOe[6], padOut[6]}, 8'h03);
        buzIn <= 1'b0;
        repeat (2) @(posedge clk);
        chk("buzLo", {7'h00, padOut[6]}, 8'h00);
        wr(1, 8'hff);
        swLevel <= 8'hdb;
        wr(6, 8'h01);
        chk("tmr", {extIntPin, timerPinValid, timerPin}, 8'h02);
        swLevel <= 8'hff;
        wr(3, 8'h01);
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        repeat (2) @(posedge clk);
        chk("slp", {sleeping, clockStop}, 8'h03);
        swLevel <= 8'hfd;
        repeat (8) @(posedge clk);
        chk("noWake", {7'h00, sleeping}, 8'h01);
        swLevel <= 8'hfc;
        i = 0;
        while (sleeping !== 1'b0 && i < 20)
        begin
            @(negedge clk);
            i = i + 1;
        end
        chk("woke", {7'h00, sleeping}, 8'h00);
        chk("wkEvt", {7'h00, wakeEvt}, 8'h01);
        $display("sleep test done");
        reportAndStop;
    end
endmodule // port_a_io_wakeup_tb
